// ---- rtl/dram_regs_defines.vh ----
/*
  Constants for the ECC, calibration and repair register bank of one
  channel. Assumes inclusion by bare name from the design files.
*/
`ifndef DRAM_REGS_DEFINES_VH
`define DRAM_REGS_DEFINES_VH

`define ADDR_REPAIR_RESOURCE   6'h19
`define ADDR_TEST_RESERVED_A   6'h1E
`define ADDR_CALIB_FIRST       6'h20
`define ADDR_ECC_CONTROL       6'h21
`define ADDR_ECC_EVENT_COUNT   6'h22
`define ADDR_TEST_RESERVED_B   6'h27
`define ADDR_CALIB_SECOND      6'h28

`define CALIB_FIRST_RESET      8'h5A
`define CALIB_SECOND_RESET     8'h3C
`define INVERT_RESET           8'h55

`define ECC_ENABLE_BIT         7
`define ERROR_PAD_BIT          6
`define ECC_CLEAR_BIT          5
`define DOUBLE_ERROR_BIT       1
`define CORRECTED_BIT          0

`define MPC_READ_CALIB         7'h43
`define COUNT_MAX              8'hFF
`define CALIB_BITS             5'd16

`endif

// ---- rtl/set_point_pair.v ----
/*
  Two-copy configuration byte: writes land in the copy picked by the
  write selector, the live value is the copy picked by the operating one.
  Assumes a single clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module set_point_pair #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_write,
  input  wire [7:0] i_data,
  input  wire       i_write_sel,
  input  wire       i_oper_sel,
  output wire [7:0] o_live,
  output wire [7:0] o_written
);
  reg [7:0] copy0_reg;
  reg [7:0] copy1_reg;

  // Only the write-selected copy takes a write; reset loads both copies
  always @(posedge i_clk) begin
    if (i_reset) begin
      copy0_reg <= RESET_VALUE;
      copy1_reg <= RESET_VALUE;
    end else if (i_write) begin
      if (i_write_sel) begin
        copy1_reg <= i_data;
      end else begin
        copy0_reg <= i_data;
      end
    end
  end

  // Inactive copy is ignored by the device
  assign o_live    = i_oper_sel ? copy1_reg : copy0_reg;
  assign o_written = i_write_sel ? copy1_reg : copy0_reg;
endmodule
`default_nettype wire

// ---- rtl/calib_shifter.v ----
/*
  Serialiser for the 16-bit read calibration pattern, one bit per clock,
  low bit of each byte first. Both patterns are captured into the shift
  register when a burst starts, so they may change while it runs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dram_regs_defines.vh"
module calib_shifter (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_start,
  input  wire [7:0] i_first,
  input  wire [7:0] i_second,
  output reg        o_active,
  output reg        o_bit
);
  reg [15:0] shift_reg;
  reg [4:0]  count_reg;

  // Second byte sits above the first so it leaves after it
  always @(posedge i_clk) begin
    if (i_reset) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      o_active  <= 1'b0;
      o_bit     <= 1'b0;
    end else if (i_start && !o_active) begin
      o_active  <= 1'b1;
      o_bit     <= i_first[0];
      shift_reg <= {1'b0, i_second, i_first[7:1]};
      count_reg <= `CALIB_BITS - 5'd1;
    end else if (o_active) begin
      if (count_reg == 5'h00) begin
        o_active <= 1'b0;
        o_bit    <= 1'b0;
      end else begin
        o_bit     <= shift_reg[0];
        shift_reg <= {1'b0, shift_reg[15:1]};
        count_reg <= count_reg - 5'd1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/dram_ecc_calib_refresh_regs.v ----
/*
  Mode register bank of one channel: repair resources, test registers,
  calibration patterns and their serial output, ECC control and status.
  Assumes decoded register read/write and multipurpose command strobes
  from the command decoder; refresh timing is kept by the controller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dram_regs_defines.vh"
module dram_ecc_calib_refresh_regs (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_reg_write,
  input  wire        i_reg_read,
  input  wire [5:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  output reg         o_reg_rvalid,
  input  wire        i_multipurpose_command,
  input  wire [6:0]  i_mpc_operand,
  input  wire        i_write_set_point_select,
  input  wire        i_operating_set_point_select,
  input  wire        i_lower_invert_write,
  input  wire        i_upper_invert_write,
  input  wire [7:0]  i_invert_wdata,
  input  wire        i_io_config_write,
  input  wire [7:0]  i_io_config_wdata,
  input  wire [7:0]  i_repair_available,
  input  wire        i_ecc_corrected,
  input  wire        i_ecc_double_error,
  output reg  [15:0] o_dq,
  output reg  [15:0] o_dq_oe,
  output reg  [1:0]  o_mask_inversion_pin,
  output reg  [1:0]  o_mask_inversion_oe,
  output wire        o_ecc_enable,
  output reg         o_error_pad
);
  reg [7:0] calib_first_reg;
  reg [7:0] calib_second_reg;
  reg       ecc_enable_reg;
  reg       error_pad_enable_reg;
  reg       double_error_flag_reg;
  reg       corrected_flag_reg;
  reg [7:0] ecc_event_count_reg;

  wire [7:0] lower_invert;
  wire [7:0] upper_invert;
  wire [7:0] io_config;
  wire       calib_active;
  wire       calib_bit;
  wire       data_bus_inversion_read;
  wire       write_hit;
  wire       record_clear;
  wire       event_seen;
  wire       double_seen;

  // All state lives in this instance, one per channel
  assign write_hit    = i_reg_write;
  assign record_clear = write_hit && (i_reg_addr == `ADDR_ECC_CONTROL) &&
                        i_reg_wdata[`ECC_CLEAR_BIT];
  // Events only count while the corrector is running
  assign event_seen  = i_ecc_corrected && ecc_enable_reg;
  assign double_seen = i_ecc_double_error && ecc_enable_reg;
  assign o_ecc_enable = ecc_enable_reg;

  // Lane invert registers, two set-point copies each, reset 55
  set_point_pair #(.RESET_VALUE(`INVERT_RESET)) lower_inv (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_write      (i_lower_invert_write),
    .i_data       (i_invert_wdata),
    .i_write_sel  (i_write_set_point_select),
    .i_oper_sel   (i_operating_set_point_select),
    .o_live       (lower_invert),
    .o_written    ()
  );
  set_point_pair #(.RESET_VALUE(`INVERT_RESET)) upper_inv (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_write      (i_upper_invert_write),
    .i_data       (i_invert_wdata),
    .i_write_sel  (i_write_set_point_select),
    .i_oper_sel   (i_operating_set_point_select),
    .o_live       (upper_invert),
    .o_written    ()
  );
  // Io config copy; only its read inversion bit matters here
  set_point_pair #(.RESET_VALUE(8'h00)) io_cfg (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_write      (i_io_config_write),
    .i_data       (i_io_config_wdata),
    .i_write_sel  (i_write_set_point_select),
    .i_oper_sel   (i_operating_set_point_select),
    .o_live       (io_config),
    .o_written    ()
  );
  assign data_bus_inversion_read = io_config[6];

  // Pattern serialiser
  calib_shifter shifter (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_start   (i_multipurpose_command && (i_mpc_operand == `MPC_READ_CALIB)),
    .i_first   (calib_first_reg),
    .i_second  (calib_second_reg),
    .o_active  (calib_active),
    .o_bit     (calib_bit)
  );

  // Calibration pattern and ECC control writes
  always @(posedge i_clk) begin
    if (i_reset) begin
      calib_first_reg      <= `CALIB_FIRST_RESET;
      calib_second_reg     <= `CALIB_SECOND_RESET;
      ecc_enable_reg       <= 1'b1;
      error_pad_enable_reg <= 1'b0;
    end else if (write_hit) begin
      case (i_reg_addr)
        `ADDR_CALIB_FIRST: begin
          calib_first_reg <= i_reg_wdata;
        end
        `ADDR_CALIB_SECOND: begin
          calib_second_reg <= i_reg_wdata;
        end
        `ADDR_ECC_CONTROL: begin
          ecc_enable_reg       <= i_reg_wdata[`ECC_ENABLE_BIT];
          error_pad_enable_reg <= i_reg_wdata[`ERROR_PAD_BIT];
        end
        default: begin
          // Test registers and others: data dropped on purpose
          calib_first_reg <= calib_first_reg;
        end
      endcase
    end
  end

  // Sticky flags and counter; an event in the clear cycle survives
  always @(posedge i_clk) begin
    if (i_reset) begin
      double_error_flag_reg <= 1'b0;
      corrected_flag_reg    <= 1'b0;
      ecc_event_count_reg   <= 8'h00;
    end else begin
      if (double_seen) begin
        double_error_flag_reg <= 1'b1;
      end else if (record_clear) begin
        double_error_flag_reg <= 1'b0;
      end
      if (event_seen) begin
        corrected_flag_reg <= 1'b1;
      end else if (record_clear) begin
        corrected_flag_reg <= 1'b0;
      end
      if (record_clear) begin
        ecc_event_count_reg <= event_seen ? 8'h01 : 8'h00;
      end else if (event_seen && (ecc_event_count_reg != `COUNT_MAX)) begin
        ecc_event_count_reg <= ecc_event_count_reg + 8'h01;
      end
    end
  end

  // Error pad follows events only while both enables hold
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_error_pad <= 1'b0;
    end else begin
      o_error_pad <= ecc_enable_reg && error_pad_enable_reg &&
                     (i_ecc_corrected || i_ecc_double_error);
    end
  end

  // Register reads, answered one cycle later; clear bit reads zero
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      if (i_reg_read) begin
        case (i_reg_addr)
          `ADDR_REPAIR_RESOURCE: o_reg_rdata <= i_repair_available;
          `ADDR_ECC_CONTROL: o_reg_rdata <= {ecc_enable_reg, error_pad_enable_reg, 1'b0, 3'b000,
                                             double_error_flag_reg, corrected_flag_reg};
          `ADDR_ECC_EVENT_COUNT: o_reg_rdata <= ecc_event_count_reg;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Pin drive: lane invert on data pins, never on mask pins, no encoding
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_dq                 <= 16'h0000;
      o_dq_oe              <= 16'h0000;
      o_mask_inversion_pin <= 2'b00;
      o_mask_inversion_oe  <= 2'b00;
    end else begin
      o_dq    <= {{8{calib_bit}} ^ upper_invert, {8{calib_bit}} ^ lower_invert};
      o_dq_oe <= {16{calib_active}};
      o_mask_inversion_pin <= {2{calib_bit & data_bus_inversion_read}};
      o_mask_inversion_oe  <= {2{calib_active & data_bus_inversion_read}};
    end
  end
endmodule
`default_nettype wire

// ---- sim/dram_regs_properties.sv ----
/*
  Port-level checker for the channel register bank.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dram_regs_checker (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_reg_read,
  input wire logic        i_reg_write,
  input wire logic        o_reg_rvalid,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_ecc_corrected,
  input wire logic        i_ecc_double_error,
  input wire logic        o_ecc_enable,
  input wire logic        o_error_pad,
  input wire logic [15:0] o_dq_oe,
  input wire logic        i_multipurpose_command,
  input wire logic [6:0]  i_mpc_operand,
  input wire logic [1:0]  o_mask_inversion_oe,
  input wire logic [1:0]  o_mask_inversion_pin
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_rd_ack; i_reg_read |=> o_reg_rvalid; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_rd_only; o_reg_rvalid |-> $past(i_reg_read); endproperty
  a_rd_only: assert property (p_rd_only) else $error("stray read valid");
  property p_rd_hold; !o_reg_rvalid |-> $stable(o_reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_pad; o_error_pad |-> $past(o_ecc_enable) && $past(i_ecc_corrected || i_ecc_double_error); endproperty
  a_pad: assert property (p_pad) else $error("error pad without cause");
  property p_en; $changed(o_ecc_enable) |-> $past(i_reg_write); endproperty
  a_en: assert property (p_en) else $error("ecc enable moved alone");
  property p_len; $rose(o_dq_oe[0]) |-> o_dq_oe[0] [*8] ##1 o_dq_oe[0] [*8] ##1 !o_dq_oe[0]; endproperty
  a_len: assert property (p_len) else $error("burst not 16 bits");
  property p_start; $rose(o_dq_oe[0]) |-> $past(i_multipurpose_command, 2) && $past(i_mpc_operand, 2) == 7'h43;
  endproperty
  a_start: assert property (p_start) else $error("burst without command");
  property p_mask; |o_mask_inversion_oe |-> o_mask_inversion_oe == 2'h3 && o_dq_oe[0] &&
    o_mask_inversion_pin[0] == o_mask_inversion_pin[1]; endproperty
  a_mask: assert property (p_mask) else $error("mask pins not true pattern");
endmodule
bind dram_ecc_calib_refresh_regs dram_regs_checker chk_i (.i_clk(i_clk), .i_reset(i_reset),
  .i_reg_read(i_reg_read), .i_reg_write(i_reg_write), .o_reg_rvalid(o_reg_rvalid), .o_reg_rdata(o_reg_rdata),
  .i_ecc_corrected(i_ecc_corrected), .i_ecc_double_error(i_ecc_double_error), .o_ecc_enable(o_ecc_enable),
  .o_error_pad(o_error_pad), .o_dq_oe(o_dq_oe), .i_multipurpose_command(i_multipurpose_command),
  .i_mpc_operand(i_mpc_operand), .o_mask_inversion_oe(o_mask_inversion_oe),
  .o_mask_inversion_pin(o_mask_inversion_pin));
`default_nettype wire

// ---- sim/ctrl_model.sv ----
/*
  Memory controller model: register commands and multipurpose commands.
  Assumes the device answers a read exactly one cycle after it.
*/
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic       i_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr = 1'b0,
  output var  logic       o_rd = 1'b0,
  output var  logic [5:0] o_addr = 6'h3F,
  output var  logic [7:0] o_wdata = 8'h00,
  output var  logic       o_mpc = 1'b0,
  output var  logic [6:0] o_op = 7'h00
);
  // Refresh duties of the controller; the block keeps no refresh state
  localparam int REFRESH_CMDS_PER_WINDOW = 8192;
  localparam int WINDOW_MS_NORMAL        = 32;
  localparam int WINDOW_MS_HALF          = 16;
  localparam int WINDOW_MS_QUARTER       = 8;
  localparam int AVG_INTERVAL_ALL_NS     = 3904;
  localparam int AVG_INTERVAL_BANK_NS    = 488;
  localparam int REFRESH_ALL_WAIT_NS     = 130;
  localparam int REFRESH_BANK_WAIT_NS    = 60;
  localparam int EXTRA_REFRESH_AFTER_EXIT = 1;
  // Released lines flip so a stale value never looks valid
  task automatic idle();
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    o_op = ~o_op;
  endtask
  // One-cycle write, same timing for test registers too
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    idle();
  endtask
  // Read; answer taken in the cycle after the command edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    ok = i_rvalid;
    d = i_rdata;
    idle();
  endtask
  task automatic multipurpose_command(input logic [6:0] op);
    @(negedge i_clk);
    o_mpc = 1'b1;
    o_op = op;
    @(negedge i_clk);
    o_mpc = 1'b0;
    idle();
  endtask
endmodule
`default_nettype wire

// ---- sim/dram_ecc_calib_refresh_regs_tb_top.sv ----
/*
  Self-checking bench for the channel register bank.
  Assumes the controller model drives register and multipurpose commands; invert and io config writes are driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module dram_ecc_calib_refresh_regs_tb_top;
  logic clk = 0, rst = 1, ws = 0, os = 0, lw = 0, uw = 0, iow = 0, corr = 0, dbl = 0;
  logic [7:0] invd = 0, iod = 0, rep = 0, rdata;
  logic wr, rd, multipurpose_command, rvalid, en, pad;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [6:0] op;
  logic [15:0] dq, dq_oe;
  logic [1:0] mip, mioe;
  int err_count = 0, n_checks = 0;
  always #5 clk = ~clk;
  ctrl_model m (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .o_mpc(multipurpose_command), .o_op(op));
  dram_ecc_calib_refresh_regs uut (.i_clk(clk), .i_reset(rst), .i_reg_write(wr), .i_reg_read(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_multipurpose_command(multipurpose_command), .i_mpc_operand(op), .i_write_set_point_select(ws),
    .i_operating_set_point_select(os), .i_lower_invert_write(lw), .i_upper_invert_write(uw),
    .i_invert_wdata(invd), .i_io_config_write(iow), .i_io_config_wdata(iod), .i_repair_available(rep),
    .i_ecc_corrected(corr), .i_ecc_double_error(dbl), .o_dq(dq), .o_dq_oe(dq_oe),
    .o_mask_inversion_pin(mip), .o_mask_inversion_oe(mioe), .o_ecc_enable(en), .o_error_pad(pad));
  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    m.rd(a, d, ok);
    chk("rvalid", 16'h1, {15'h0, ok});
    chk("rdata", {8'h0, e}, {8'h0, d});
  endtask
  // Streams are checked on all 16 pins at once, bit by bit
  task automatic burst(input logic [15:0] p, input logic [15:0] inv, input logic data_bus_inversion);
    m.multipurpose_command(7'h43);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      chk("dq", {16{p[i]}} ^ inv, dq);
      chk("dq_oe", 16'hFFFF, dq_oe);
      chk("mask", data_bus_inversion ? {12'h0, 2'h3, {2{p[i]}}} : 16'h0, {12'h0, mioe, mip});
    end
    @(negedge clk);
    chk("dq_oe end", 16'h0, dq_oe);
  endtask
  // Multi-cycle events arrive one per clock
  task automatic ev(input logic c, input logic d, input int n);
    @(negedge clk);
    corr = c;
    dbl = d;
    repeat (n) @(negedge clk);
    corr = 0;
    dbl = 0;
  endtask
  task automatic inv_wr(input logic lo, input logic [7:0] d);
    @(negedge clk);
    invd = d;
    lw = lo;
    uw = !lo;
    @(negedge clk);
    lw = 0;
    uw = 0;
  endtask
  task automatic t_regs();
    rep = 8'hA5;
    rchk(6'h19, 8'hA5);
    rep = 8'h5A;
    rchk(6'h19, 8'h5A);
    rchk(6'h21, 8'h80);
    rchk(6'h22, 8'h00);
    rchk(6'h20, 8'h00);
    chk("ecc_en", 16'h1, {15'h0, en});
  endtask
  task automatic t_test_regs();
    m.wr(6'h1E, 8'hFF);
    m.wr(6'h27, 8'hFF);
    rchk(6'h21, 8'h80);
    burst(16'h3C5A, 16'h5555, 0);
  endtask
  task automatic t_calib();
    ws = 1;
    inv_wr(1, 8'h0F);
    ws = 0;
    inv_wr(0, 8'hF0);
    @(negedge clk);
    iod = 8'h40;
    iow = 1;
    @(negedge clk);
    iow = 0;
    m.wr(6'h20, 8'hA1);
    m.wr(6'h28, 8'h27);
    burst(16'h27A1, 16'hF055, 1);
  endtask
  task automatic t_ecc();
    ev(1, 0, 3);
    ev(0, 1, 1);
    rchk(6'h21, 8'h83);
    rchk(6'h22, 8'h03);
    m.wr(6'h21, 8'hC0);
    ev(1, 0, 1);
    chk("pad", 16'h1, {15'h0, pad});
    m.wr(6'h21, 8'hA0);
    rchk(6'h21, 8'h80);
    rchk(6'h22, 8'h00);
    ev(1, 0, 260);
    rchk(6'h22, 8'hFF);
    m.wr(6'h21, 8'h00);
    chk("ecc_en", 16'h0, {15'h0, en});
    ev(1, 1, 2);
    rchk(6'h21, 8'h01);
  endtask
  // Watchdog at 10000 cycles, well past the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_regs();
    t_test_regs();
    t_calib();
    t_ecc();
    conclude();
  end
endmodule
`default_nettype wire
